// >>> host_kicker.sv
// Host processor model that toggles the kick line.
// Assumes the bench clock; it changes the line just after falling edges.
module host_kicker (
  // Clock
  input  wire logic       core_clk,
  // Control
  input  wire logic       kick_en,
  input  wire logic [7:0] kick_gap,
  // Kick line
  output logic            wdt_kick_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] gap_q = 8'h00;
  initial wdt_kick_in = 1'b0;
  // Toggles once every kick_gap plus one clocks while enabled.
  always @(negedge core_clk) begin
    if (kick_en && gap_q >= kick_gap) begin
      wdt_kick_in <= !wdt_kick_in;
      gap_q       <= 8'h00;
    end else begin
      gap_q <= gap_q + 8'h01;
    end
  end
endmodule

// >>> supervisor_watchdog_timer.sv
// Watchdog timer of a multi-rail system manager: kick supervision, fault output
// and optional system reset request, in dependent or independent mode.
// Assumes register accesses come from the serial interface logic as single-cycle
// strobes, and that the sequencer supplies its status levels synchronously.
//
// How it works
// - Config bits 2:0 select normal timeout.
// - Config bits 4:3 select startup delay.
// - Config bit 5 enables the watchdog.
// - Config bit 6 inserts startup delay, both modes.
// - Config bit 7 lets expiry request reset.
// - Control bit 3 set selects independent mode.
// - Independent: active after lockout clears, boot done.
// - Independent: sequencer reset leaves watchdog untouched.
// - Reset expiry: fault, then reset, then release.
// - Fault lasts exactly three clocks then.
// - No reset enable: fault only, reset untouched.
// - Control bit 3 clear selects dependent mode.
// - Dependent: wait sequencing, cleared during reset.
// - No reset enable: missed kick holds fault until kick/reset.
// - Timeout counting starts once active, without a kick.
`include "supervisor_watchdog_timer_regs.svh"

module supervisor_watchdog_timer #(
  parameter int unsigned TICK_CYCLES = `WDT_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rdata,
  // System status
  input  wire logic       lockout_clear,
  input  wire logic       boot_done,
  input  wire logic       seq_done,
  input  wire logic       sys_reset_in,
  // Watchdog pins
  input  wire logic       wdt_kick_in,
  output logic            wdt_fault_out,
  output logic            sys_reset_req
);

  supervisor_watchdog_timer_pkg::wdt_top_s st_q;
  supervisor_watchdog_timer_pkg::wdt_top_s st_d;

  logic kick_edge;
  logic tick;

  // --------------------------------------------------------------------------
  // Timing lookups
  // --------------------------------------------------------------------------
  function automatic logic limit_hit(
    input supervisor_watchdog_timer_pkg::wdt_cnt_t cnt,
    input supervisor_watchdog_timer_pkg::wdt_cnt_t limit
  );
    return (cnt + 1'b1) >= limit;
  endfunction

  function automatic supervisor_watchdog_timer_pkg::wdt_cnt_t timeout_ticks(
    input logic [2:0] code
  );
    int unsigned us;
    case (code)
      3'h0:    us = `WDT_TO0_US;
      3'h1:    us = `WDT_TO1_US;
      3'h2:    us = `WDT_TO2_US;
      3'h3:    us = `WDT_TO3_US;
      3'h4:    us = `WDT_TO4_US;
      3'h5:    us = `WDT_TO5_US;
      3'h6:    us = `WDT_TO6_US;
      default: us = `WDT_TO7_US;
    endcase
    return `WDT_CNT_W'(us / `WDT_TICK_US);
  endfunction

  function automatic supervisor_watchdog_timer_pkg::wdt_cnt_t startup_ticks(
    input logic [1:0] code
  );
    int unsigned us;
    case (code)
      2'h0:    us = `WDT_SU0_US;
      2'h1:    us = `WDT_SU1_US;
      2'h2:    us = `WDT_SU2_US;
      default: us = `WDT_SU3_US;
    endcase
    return `WDT_CNT_W'(us / `WDT_TICK_US);
  endfunction

  // --------------------------------------------------------------------------
  // Kick synchroniser and tick prescaler
  // --------------------------------------------------------------------------
  wdt_kick_sync u_kick (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .kick_in   (wdt_kick_in),
    .kick_edge (kick_edge)
  );

  wdt_tick_div #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .tick     (tick)
  );

  // --------------------------------------------------------------------------
  // Configuration decode
  // --------------------------------------------------------------------------
  logic       cfg_en;
  logic       cfg_su_en;
  logic       cfg_rst_en;
  logic       indep_mode;
  logic       active;
  supervisor_watchdog_timer_pkg::wdt_cnt_t to_limit;
  supervisor_watchdog_timer_pkg::wdt_cnt_t su_limit;

  assign cfg_en     = st_q.cfg[`WDT_CFG_EN_BIT];
  assign cfg_su_en  = st_q.cfg[`WDT_CFG_SUEN_BIT];
  assign cfg_rst_en = st_q.cfg[`WDT_CFG_RSTEN_BIT];
  assign indep_mode = st_q.ctrl[`WDT_CTRL_MODE_BIT];
  assign to_limit   = timeout_ticks(st_q.cfg[`WDT_CFG_TO_MSB:`WDT_CFG_TO_LSB]);
  assign su_limit   = startup_ticks(st_q.cfg[`WDT_CFG_SU_MSB:`WDT_CFG_SU_LSB]);

  // Independent mode ignores sequencing and system reset entirely.
  always_comb begin
    if (indep_mode) begin
      active = cfg_en && lockout_clear && boot_done;
    end else begin
      active = cfg_en && seq_done && !sys_reset_in;
    end
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.rst_pulse = 1'b0;

    // Register writes and reads.
    if (reg_wr_en) begin
      if (reg_addr == `WDT_CFG_OFS) begin
        st_d.cfg = reg_wdata;
      end else if (reg_addr == `WDT_CTRL_OFS) begin
        st_d.ctrl = reg_wdata;
      end
    end
    if (reg_rd_en) begin
      case (reg_addr)
        `WDT_CFG_OFS:    st_d.rdata = st_q.cfg;
        `WDT_CTRL_OFS:   st_d.rdata = st_q.ctrl;
        `WDT_STATUS_OFS: st_d.rdata = {5'h00, st_q.state == supervisor_watchdog_timer_pkg::ST_STARTUP,
                                       st_q.state != supervisor_watchdog_timer_pkg::ST_OFF, st_q.fault};
        default:         st_d.rdata = 8'h00;
      endcase
    end

    if (!active) begin
      // Disabled, waiting on lockout/boot (independent) or sequencing, or held by reset in dependent mode.
      st_d.state     = supervisor_watchdog_timer_pkg::ST_OFF;
      st_d.cnt       = '0;
      st_d.pulse_cnt = 2'h0;
      st_d.fault     = 1'b0;
    end else begin
      case (st_q.state)
        supervisor_watchdog_timer_pkg::ST_OFF: begin
          st_d.cnt = '0;
          if (cfg_su_en) begin
            st_d.state = supervisor_watchdog_timer_pkg::ST_STARTUP;
          end else begin
            st_d.state = supervisor_watchdog_timer_pkg::ST_RUN;
          end
        end
        supervisor_watchdog_timer_pkg::ST_STARTUP: begin
          if (kick_edge) begin
            st_d.state = supervisor_watchdog_timer_pkg::ST_RUN;
            st_d.cnt   = '0;
          end else if (tick) begin
            if (limit_hit(st_q.cnt, su_limit)) begin
              st_d.cnt = '0;
              if (cfg_rst_en) begin
                st_d.state     = supervisor_watchdog_timer_pkg::ST_PULSE;
                st_d.pulse_cnt = 2'h0;
                st_d.fault     = 1'b1;
              end else begin
                st_d.state = supervisor_watchdog_timer_pkg::ST_EXPIRED;
                st_d.fault = 1'b1;
              end
            end else begin
              st_d.cnt = st_q.cnt + 1'b1;
            end
          end
        end
        supervisor_watchdog_timer_pkg::ST_RUN: begin
          if (kick_edge) begin
            st_d.cnt = '0;
          end else if (tick) begin
            if (limit_hit(st_q.cnt, to_limit)) begin
              st_d.cnt = '0;
              if (cfg_rst_en) begin
                st_d.state     = supervisor_watchdog_timer_pkg::ST_PULSE;
                st_d.pulse_cnt = 2'h0;
                st_d.fault     = 1'b1;
              end else begin
                st_d.state = supervisor_watchdog_timer_pkg::ST_EXPIRED;
                st_d.fault = 1'b1;
              end
            end else begin
              st_d.cnt = st_q.cnt + 1'b1;
            end
          end
        end
        supervisor_watchdog_timer_pkg::ST_EXPIRED: begin
          // Fault holds until the host kicks again.
          if (kick_edge) begin
            st_d.state = supervisor_watchdog_timer_pkg::ST_RUN;
            st_d.fault = 1'b0;
            st_d.cnt   = '0;
          end
        end
        supervisor_watchdog_timer_pkg::ST_PULSE: begin
          // Fault for three clocks, reset request in the second.
          if (st_q.pulse_cnt == 2'h0) begin
            st_d.rst_pulse = 1'b1;
          end
          if (st_q.pulse_cnt == 2'(`WDT_FAULT_PULSE_CYC - 1)) begin
            st_d.fault = 1'b0;
            st_d.cnt   = '0;
            st_d.state = cfg_su_en ? supervisor_watchdog_timer_pkg::ST_STARTUP
                                   : supervisor_watchdog_timer_pkg::ST_RUN;
          end else begin
            st_d.pulse_cnt = st_q.pulse_cnt + 2'h1;
          end
        end
        default: begin
          st_d.state = supervisor_watchdog_timer_pkg::ST_OFF;
          st_d.fault = 1'b0;
          st_d.cnt   = '0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q.state     <= supervisor_watchdog_timer_pkg::ST_OFF;
      st_q.cnt       <= '0;
      st_q.pulse_cnt <= 2'h0;
      st_q.fault     <= 1'b0;
      st_q.rst_pulse <= 1'b0;
      st_q.cfg       <= `WDT_CFG_RESET;
      st_q.ctrl      <= `WDT_CTRL_RESET;
      st_q.rdata     <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign reg_rdata     = st_q.rdata;
  assign wdt_fault_out = st_q.fault;
  assign sys_reset_req = st_q.rst_pulse;

endmodule

// >>> supervisor_watchdog_timer_checker.sv
// Assertion checker for the watchdog top module.
// Assumes it is bound to supervisor_watchdog_timer and sees only its ports.
module wdt_checker #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rdata,
  // System status
  input wire logic       lockout_clear,
  input wire logic       boot_done,
  input wire logic       seq_done,
  input wire logic       sys_reset_in,
  // Watchdog pins
  input wire logic       wdt_kick_in,
  input wire logic       wdt_fault_out,
  input wire logic       sys_reset_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // --------
  // Shadow settings, kick history and quiet time.
  // --------
  logic [7:0] cfg_q;
  logic [7:0] ctrl_q;
  logic [4:0] kick_q;
  int         quiet_q;
  logic       act;
  logic       still;
  assign act   = cfg_q[5] & (ctrl_q[3] ? lockout_clear & boot_done : seq_done & !sys_reset_in);
  assign still = (&{kick_q, wdt_kick_in}) | ~(|{kick_q, wdt_kick_in});
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q   <= 8'h00;
      ctrl_q  <= 8'h01;
      kick_q  <= 5'h00;
      quiet_q <= 0;
    end else begin
      if (reg_wr_en && reg_addr == 8'h55) begin
        cfg_q <= reg_wdata;
      end
      if (reg_wr_en && reg_addr == 8'h4D) begin
        ctrl_q <= reg_wdata;
      end
      kick_q  <= {kick_q[3:0], wdt_kick_in};
      quiet_q <= (!act || wdt_fault_out || !still || reg_wr_en) ? 0 : quiet_q + 1;
    end
  end

  // --------
  // Properties.
  // --------
  chk_pulse_shape: assert property ($rose(sys_reset_req) |-> !$past(wdt_fault_out, 2) &&
    $past(wdt_fault_out) && wdt_fault_out ##1 wdt_fault_out && !sys_reset_req ##1 !wdt_fault_out)
    else $error("reset request not framed by a three-cycle fault pulse");
  chk_req_single: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than one cycle");
  chk_req_enable: assert property (sys_reset_req |-> cfg_q[7] && act)
    else $error("reset request without reset enable");
  chk_idle_quiet: assert property (!act ##1 !act |-> !wdt_fault_out && !sys_reset_req)
    else $error("fault or request while inactive");
  chk_fault_hold: assert property (wdt_fault_out && !cfg_q[7] && act && still |=> wdt_fault_out)
    else $error("fault released without a kick");
  chk_expiry_time: assert property ($rose(wdt_fault_out) && cfg_q[2:0] == 3'h0 && !cfg_q[6]
    |-> quiet_q >= 9 * TICK_CYCLES && quiet_q <= 10 * TICK_CYCLES + 8)
    else $error("shortest timeout out of window");
  chk_cfg_read: assert property (reg_rd_en && reg_addr == 8'h55 |=> reg_rdata == $past(cfg_q))
    else $error("config read back wrong");
  chk_mode_read: assert property (reg_rd_en && reg_addr == 8'h4D |=> reg_rdata == $past(ctrl_q))
    else $error("control read back wrong");
  cover property ($rose(sys_reset_req));
  cover property (wdt_fault_out && ctrl_q[3] && sys_reset_in);
  cover property ($fell(wdt_fault_out) && !cfg_q[7]);
endmodule

bind supervisor_watchdog_timer wdt_checker #(.TICK_CYCLES(TICK_CYCLES)) u_wdt_checker (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
  .lockout_clear(lockout_clear), .boot_done(boot_done), .seq_done(seq_done),
  .sys_reset_in(sys_reset_in), .wdt_kick_in(wdt_kick_in), .wdt_fault_out(wdt_fault_out),
  .sys_reset_req(sys_reset_req)
);

// >>> supervisor_watchdog_timer_pkg.sv
// Types shared by the watchdog modules.
// Assumes the register header is on the include path.
`include "supervisor_watchdog_timer_regs.svh"

package supervisor_watchdog_timer_pkg;

  // --------------------------------------------------------------------------
  // Watchdog states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF,
    ST_STARTUP,
    ST_RUN,
    ST_EXPIRED,
    ST_PULSE
  } wdt_state_e;

  typedef logic [`WDT_CNT_W-1:0] wdt_cnt_t;

  // --------------------------------------------------------------------------
  // Register state of the top module
  // --------------------------------------------------------------------------
  typedef struct packed {
    wdt_state_e state;
    wdt_cnt_t   cnt;
    logic [1:0] pulse_cnt;
    logic       fault;
    logic       rst_pulse;
    logic [7:0] cfg;
    logic [7:0] ctrl;
    logic [7:0] rdata;
  } wdt_top_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic edge_seen;
  } kick_sync_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tick_div_s;

endpackage

// >>> supervisor_watchdog_timer_regs.svh
// Register offsets, field positions, reset values and timing figures of the watchdog.
// Assumes a 20 MHz core clock; included by the package and the design modules.
`ifndef SUPERVISOR_WATCHDOG_TIMER_REGS_SVH
`define SUPERVISOR_WATCHDOG_TIMER_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define WDT_CTRL_OFS        8'h4D
`define WDT_CFG_OFS         8'h55
`define WDT_STATUS_OFS      8'h56

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WDT_CFG_TO_LSB      0
`define WDT_CFG_TO_MSB      2
`define WDT_CFG_SU_LSB      3
`define WDT_CFG_SU_MSB      4
`define WDT_CFG_EN_BIT      5
`define WDT_CFG_SUEN_BIT    6
`define WDT_CFG_RSTEN_BIT   7
`define WDT_CTRL_MODE_BIT   3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define WDT_CFG_RESET       8'h00
`define WDT_CTRL_RESET      8'h01

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDT_CLK_PERIOD_NS   50
`define WDT_TICK_US         100
`define WDT_TICK_CYCLES     (`WDT_TICK_US * 1000 / `WDT_CLK_PERIOD_NS)
`define WDT_TO0_US          1000
`define WDT_TO1_US          4000
`define WDT_TO2_US          12500
`define WDT_TO3_US          50000
`define WDT_TO4_US          200000
`define WDT_TO5_US          800000
`define WDT_TO6_US          1600000
`define WDT_TO7_US          3200000
`define WDT_SU0_US          25600000
`define WDT_SU1_US          51200000
`define WDT_SU2_US          102400000
`define WDT_SU3_US          128000000
`define WDT_FAULT_PULSE_CYC 3
`define WDT_CNT_W           24

`endif

// >>> tb_supervisor_watchdog_timer.sv
// Self-checking bench for the watchdog timer.
// Assumes the design, the checker and the host model are compiled first.
module tb_supervisor_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TC = 2;
  typedef struct {
    logic [7:0] cfg;
    logic [7:0] ctrl;
    logic       srst;
    int         ticks;
    logic       req;
  } row_s;
  row_s rows[5] = '{'{8'h20, 8'h08, 1'b1, 10, 1'b0}, '{8'hA1, 8'h08, 1'b1, 40, 1'b1},
    '{8'h22, 8'h00, 1'b0, 125, 1'b0}, '{8'hA3, 8'h00, 1'b0, 500, 1'b1},
    '{8'h24, 8'h08, 1'b1, 2000, 1'b0}};
  logic       core_clk      = 1'b0;
  logic       arst_n        = 1'b0;
  logic [7:0] reg_addr      = 8'h00;
  logic       reg_wr_en     = 1'b0;
  logic [7:0] reg_wdata     = 8'h00;
  logic       reg_rd_en     = 1'b0;
  logic       lockout_clear = 1'b1;
  logic       boot_done     = 1'b1;
  logic       seq_done      = 1'b0;
  logic       sys_reset_in  = 1'b0;
  logic       kick_en       = 1'b0;
  logic [7:0] kick_gap      = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] rd_v;
  logic       wdt_kick_in;
  logic       wdt_fault_out;
  logic       sys_reset_req;
  int         err_total     = 0;
  int         n_compared    = 0;
  int         cyc           = 0;
  int         n;

  initial forever #25 core_clk = ~core_clk;

  supervisor_watchdog_timer #(.TICK_CYCLES(TC)) u_supervisor_watchdog_timer (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .lockout_clear(lockout_clear), .boot_done(boot_done), .seq_done(seq_done),
    .sys_reset_in(sys_reset_in), .wdt_kick_in(wdt_kick_in), .wdt_fault_out(wdt_fault_out),
    .sys_reset_req(sys_reset_req));
  host_kicker u_host_kicker (.core_clk(core_clk), .kick_en(kick_en), .kick_gap(kick_gap),
    .wdt_kick_in(wdt_kick_in));

  // --------
  // Tasks.
  // --------
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(logic [7:0] a);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    rd_v      = reg_rdata;
    @(negedge core_clk);
  endtask
  task automatic wait_fault(int lim);
    n = 0;
    while (wdt_fault_out !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic kick_once();
    kick_gap <= 8'h00;
    kick_en  <= 1'b1;
    @(negedge core_clk);
    kick_en <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      report_and_stop();
    end
  end

  // --------
  // Sequence.
  // --------
  initial begin
    repeat (20) @(negedge core_clk);
    arst_n = 1'b1;
    foreach (rows[i]) begin
      wr(8'h55, 8'h00);
      sys_reset_in = rows[i].srst;
      seq_done     = !rows[i].srst;
      wr(8'h4D, rows[i].ctrl);
      wr(8'h55, rows[i].cfg);
      wait_fault(rows[i].ticks * TC + 40);
      check("expiry", 1'b1, n >= (rows[i].ticks - 1) * TC - 2 && n <= rows[i].ticks * TC + 8);
      @(negedge core_clk);
      check("reset request", rows[i].req, sys_reset_req);
      repeat (2) @(negedge core_clk);
      check("fault after pulse", !rows[i].req, wdt_fault_out);
      kick_once();
      repeat (8) @(negedge core_clk);
      check("fault after kick", 1'b0, wdt_fault_out);
      rd(8'h55);
      check("config", rows[i].cfg, rd_v);
    end
    wr(8'h55, 8'h00);
    sys_reset_in = 1'b0;
    boot_done    = 1'b0;
    wr(8'h4D, 8'h08);
    wr(8'h55, 8'h60);
    repeat (10) @(negedge core_clk);
    rd(8'h56);
    check("status before boot", 8'h00, rd_v);
    boot_done     = 1'b1;
    lockout_clear = 1'b0;
    repeat (10) @(negedge core_clk);
    rd(8'h56);
    check("status in lockout", 8'h00, rd_v);
    lockout_clear = 1'b1;
    repeat (100) @(negedge core_clk);
    rd(8'h56);
    check("startup status", 8'h06, rd_v);
    kick_gap <= 8'h0F;
    kick_en  <= 1'b1;
    repeat (200) @(negedge core_clk);
    rd(8'h56);
    check("kicked status", 8'h02, rd_v);
    kick_en <= 1'b0;
    wait_fault(60);
    check("fault after kicks stop", 1'b1, wdt_fault_out);
    sys_reset_in = 1'b1;
    repeat (2) @(negedge core_clk);
    check("fault under system reset", 1'b1, wdt_fault_out);
    sys_reset_in = 1'b0;
    wr(8'h55, 8'h00);
    seq_done = 1'b0;
    wr(8'h4D, 8'h00);
    wr(8'h55, 8'h20);
    repeat (100) @(negedge core_clk);
    rd(8'h56);
    check("dependent idle", 8'h00, rd_v);
    seq_done = 1'b1;
    wait_fault(40);
    check("dependent expiry", 1'b1, wdt_fault_out);
    sys_reset_in = 1'b1;
    repeat (2) @(negedge core_clk);
    check("cleared by reset", 1'b0, wdt_fault_out);
    sys_reset_in = 1'b0;
    wait_fault(40);
    wr(8'h55, 8'h00);
    @(negedge core_clk);
    check("cleared by disable", 1'b0, wdt_fault_out);
    wr(8'h33, 8'hFF);
    rd(8'h55);
    check("no alias write", 8'h00, rd_v);
    rd(8'h33);
    check("unmapped read", 8'h00, rd_v);
    arst_n = 1'b0;
    @(negedge core_clk);
    check("fault in reset", 1'b0, wdt_fault_out);
    arst_n = 1'b1;
    rd(8'h4D);
    check("mode after reset", 8'h01, rd_v);
    report_and_stop();
  end
endmodule

// >>> wdt_kick_sync.sv
// Kick input synchroniser and either-edge detector.
// Assumes the kick input is a slow level from the host processor.
`include "supervisor_watchdog_timer_regs.svh"

module wdt_kick_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Kick
  input  wire logic kick_in,
  output logic      kick_edge
);

  supervisor_watchdog_timer_pkg::kick_sync_s st_q;
  supervisor_watchdog_timer_pkg::kick_sync_s st_d;

  // --------------------------------------------------------------------------
  // Two flip-flops, then compare the settled level with its last value.
  // --------------------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.s1        = kick_in;
    st_d.s2        = st_q.s1;
    st_d.s3        = st_q.s2;
    st_d.edge_seen = st_q.s2 ^ st_q.s3;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign kick_edge = st_q.edge_seen;

endmodule

// >>> wdt_tick_div.sv
// Prescaler producing a one-cycle tick enable every CYCLES clocks.
// Assumes CYCLES is at least 2 and fits in 16 bits.
`include "supervisor_watchdog_timer_regs.svh"

module wdt_tick_div #(
  parameter int unsigned CYCLES = `WDT_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Tick
  output logic      tick
);

  supervisor_watchdog_timer_pkg::tick_div_s st_q;
  supervisor_watchdog_timer_pkg::tick_div_s st_d;

  localparam logic [15:0] LAST = 16'(CYCLES - 1);

  // --------------------------------------------------------------------------
  // Free running divider.
  // --------------------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == LAST) begin
      st_d.cnt  = 16'h0000;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule
